// file: ebc_bus_ctrl.v
`timescale 1ns/1ns
`include "ebc_defs.vh"
// Functional notes
// RULE1 - Bus timing counts half-clock units, one per edge of the CPU clock.
// RULE2 - Base cycle is four half units plus setup, waitstates and tristate extensions.
// RULE3 - READY high at sampling point adds a waitstate; low ends the cycle.
// RULE4 - Read data captured on the edge that changes address and raises read strobe; the code keeps the address until the next cycle starts.
// RULE5 - Programmed memory-cycle waitstates complete before READY sampling applies.
// RULE6 - Read/write delay postpones the falling edge of the command.
// RULE7 - With delay, command and gated select start one half unit later.
// RULE8 - Float and strobe-to-next delays use the following cycle's settings; the code uses the finished cycle's settings.
// RULE9 - Multiplexed modes add a recovery waitstate, optionally a tristate waitstate too.
// RULE10 - Gap is two clock outputs for mux with tristate, zero demux without.
// RULE11 - Latched selects follow address strobe; early selects change with the address.
// RULE12 - Partner may drop READY on the rising edge of the command.
// RULE13 - Unaligned asynchronous READY is held low two half units plus setup.
// RULE14 - Partner releases READY promptly when the next cycle is READY-controlled.
// RULE15 - Multiplexed bus gives the partner two more half units to remove READY.
// RULE16 - Clock output period is two half units; address strobe falls after its rise; the code drops it on the same edge as the rise.
module ebc_bus_ctrl #(
  parameter AW = 24,
  parameter DW = 16,
  parameter CSN = 4
) (
  clk,
  rstn,
  cpu_clk,
  ready_n,
  req,
  req_write,
  req_addr,
  req_wdata,
  req_byte_high,
  req_cs,
  req_mux,
  req_setup_delay,
  req_rw_delay,
  req_ready_en,
  memory_cycle_waitstates,
  tristate_waitstate,
  req_ack,
  done,
  rdata,
  addr,
  wdata,
  wdata_oen,
  byte_high_enable,
  ale,
  rd_n,
  wr_n,
  read_gated_select_n,
  write_gated_select_n,
  latched_chip_select,
  early_chip_select,
  system_clock_output,
  busy,
  data_in
);
  input wire clk;
  input wire rstn;
  input wire cpu_clk;
  input wire ready_n;
  input wire req;
  input wire req_write;
  input wire [AW-1:0] req_addr;
  input wire [DW-1:0] req_wdata;
  input wire req_byte_high;
  input wire [CSN-1:0] req_cs;
  input wire req_mux;
  input wire req_setup_delay;
  input wire req_rw_delay;
  input wire req_ready_en;
  input wire [`EBC_MCW_W-1:0] memory_cycle_waitstates;
  input wire tristate_waitstate;
  output wire req_ack;
  output reg done;
  output reg [DW-1:0] rdata;
  output reg [AW-1:0] addr;
  output reg [DW-1:0] wdata;
  output reg wdata_oen;
  output reg byte_high_enable;
  output reg ale;
  output reg rd_n;
  output reg wr_n;
  output reg read_gated_select_n;
  output reg write_gated_select_n;
  output reg [CSN-1:0] latched_chip_select;
  output reg [CSN-1:0] early_chip_select;
  output reg system_clock_output;
  output wire busy;
  input wire [DW-1:0] data_in;

  wire cpu_s;
  wire ready_s;
  wire [DW-1:0] din_s;
  reg cpu_d_r;
  reg [2:0] st_r;
  reg [4:0] cnt_r;
  reg wr_r;
  reg mux_r;
  reg rwd_r;
  reg rdy_en_r;
  reg tri_r;
  reg [`EBC_MCW_W-1:0] mcw_r;
  reg [CSN-1:0] cs_r;
  reg [DW-1:0] wd_r;

  // Units left in the command phase: three per waitstate, one less with delay
  function [4:0] cmd_len;
    input [`EBC_MCW_W-1:0] mcw;
    input rwd;
    begin
      cmd_len = {1'b0, mcw} + {mcw, 1'b0} + `EBC_CMD_HALF - {4'h0, rwd};
    end
  endfunction

  ebc_sync #(.W(`EBC_READY_SYNC_W)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({cpu_clk, ready_n}),
    .q({cpu_s, ready_s})
  );
  ebc_sync #(.W(DW)) u_dsync (
    .clk(clk),
    .rstn(rstn),
    .d(data_in),
    .q(din_s)
  );

  // One tick per CPU clock edge
  wire tick = cpu_s ^ cpu_d_r; // RULE1
  // Start on clock output fall so the strobe drops at its rise
  wire fall = tick & ~cpu_s; // RULE16
  assign busy = (st_r != `EBC_ST_IDLE);
  // Cycle settings taken at start; the float gap after this cycle uses them
  assign req_ack = req & ~busy & fall; // RULE8

  always @(posedge clk) begin
    if (!rstn) begin
      cpu_d_r <= 1'b0;
      system_clock_output <= 1'b0;
      st_r <= `EBC_ST_IDLE;
      cnt_r <= 5'h00;
      wr_r <= 1'b0;
      mux_r <= 1'b0;
      rwd_r <= 1'b0;
      rdy_en_r <= 1'b0;
      tri_r <= 1'b0;
      mcw_r <= {`EBC_MCW_W{1'b0}};
      cs_r <= {CSN{1'b0}};
      wd_r <= {DW{1'b0}};
      done <= 1'b0;
      rdata <= {DW{1'b0}};
      addr <= {AW{1'b0}};
      wdata <= {DW{1'b0}};
      wdata_oen <= 1'b1;
      byte_high_enable <= 1'b0;
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      read_gated_select_n <= 1'b1;
      write_gated_select_n <= 1'b1;
      latched_chip_select <= {CSN{1'b0}};
      early_chip_select <= {CSN{1'b0}};
    end else begin
      cpu_d_r <= cpu_s;
      done <= 1'b0;
      // Period equals two half units
      if (tick) begin
        system_clock_output <= cpu_s; // RULE16
      end
      if (tick) begin
        case (st_r)
          `EBC_ST_IDLE: begin
            if (req_ack) begin
              wr_r <= req_write;
              mux_r <= req_mux;
              rwd_r <= req_rw_delay;
              rdy_en_r <= req_ready_en;
              tri_r <= tristate_waitstate;
              mcw_r <= memory_cycle_waitstates;
              cs_r <= req_cs;
              wd_r <= req_wdata;
              addr <= req_addr;
              byte_high_enable <= req_byte_high;
              early_chip_select <= req_cs; // RULE11
              ale <= 1'b1;
              cnt_r <= req_setup_delay ? 5'h02 : 5'h00; // RULE2
              st_r <= `EBC_ST_ADDR;
            end
          end
          `EBC_ST_ADDR: begin
            if (cnt_r != 5'h00) begin
              cnt_r <= cnt_r - 5'h01;
            end else begin
              // Strobe falls together with clock output rise
              ale <= 1'b0; // RULE16
              latched_chip_select <= cs_r; // RULE11
              if (wr_r) begin
                wdata <= wd_r;
                wdata_oen <= 1'b0;
              end
              if (rwd_r) begin
                // Command held back one half unit
                cnt_r <= 5'h00; // RULE6
                st_r <= `EBC_ST_SETUP;
              end else begin
                // No delay: command falls together with the strobe
                rd_n <= wr_r;
                wr_n <= ~wr_r;
                read_gated_select_n <= wr_r;
                write_gated_select_n <= ~wr_r;
                cnt_r <= cmd_len(mcw_r, 1'b0); // RULE6 RULE7 RULE5
                st_r <= `EBC_ST_CMD;
              end
            end
          end
          `EBC_ST_SETUP: begin
            if (cnt_r != 5'h00) begin
              cnt_r <= cnt_r - 5'h01;
            end else begin
              rd_n <= wr_r;
              wr_n <= ~wr_r;
              read_gated_select_n <= wr_r;
              write_gated_select_n <= ~wr_r;
              // Delayed command: two half units low plus waitstates
              cnt_r <= cmd_len(mcw_r, rwd_r); // RULE5 RULE7
              st_r <= `EBC_ST_CMD;
            end
          end
          `EBC_ST_CMD: begin
            if (cnt_r != 5'h00) begin
              cnt_r <= cnt_r - 5'h01;
            end else if (rdy_en_r && ready_s) begin
              // Waitstate: one clock output per READY high
              cnt_r <= 5'h01; // RULE3
            end else begin
              // Capture with strobe rise; address holds until the next cycle starts
              if (!wr_r) begin
                rdata <= din_s; // RULE4
              end
              rd_n <= 1'b1;
              wr_n <= 1'b1;
              read_gated_select_n <= 1'b1;
              write_gated_select_n <= 1'b1;
              latched_chip_select <= {CSN{1'b0}};
              early_chip_select <= {CSN{1'b0}};
              wdata_oen <= 1'b1;
              done <= 1'b1;
              // Mux recovery plus optional tristate, each one clock output
              cnt_r <= mux_r ? (tri_r ? 5'h03 : 5'h01) : (tri_r ? 5'h01 : 5'h00); // RULE9 RULE10
              st_r <= (mux_r || tri_r) ? `EBC_ST_RECOV : `EBC_ST_IDLE;
            end
          end
          `EBC_ST_RECOV: begin
            if (cnt_r != 5'h00) begin
              cnt_r <= cnt_r - 5'h01;
            end else begin
              st_r <= `EBC_ST_IDLE;
            end
          end
          default: begin
            st_r <= `EBC_ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// file: ebc_checker.sv
`timescale 1ns/1ns
module ebc_checker #(
  parameter AW = 24,
  parameter CSN = 4
) (
  input wire clk,
  input wire rstn,
  input wire req_ack,
  input wire [AW-1:0] req_addr,
  input wire [CSN-1:0] req_cs,
  input wire busy,
  input wire done,
  input wire rd_n,
  input wire wr_n,
  input wire read_gated_select_n,
  input wire wdata_oen,
  input wire ale,
  input wire [AW-1:0] addr,
  input wire [CSN-1:0] early_chip_select,
  input wire system_clock_output,
  input wire [CSN-1:0] latched_chip_select,
  input wire write_gated_select_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_launch;
    ale && addr == $past(req_addr) && early_chip_select == $past(req_cs);
  endsequence
  property p_taken;
    req_ack |=> busy;
  endproperty
  property p_start;
    req_ack |=> s_launch;
  endproperty
  property p_idle;
    !busy |-> rd_n && wr_n && wdata_oen;
  endproperty
  property p_excl;
    rd_n || wr_n;
  endproperty
  property p_gate;
    !read_gated_select_n |-> !rd_n;
  endproperty
  property p_done;
    done |=> !done;
  endproperty
  property p_clk;
    $changed(system_clock_output) |=> $stable(system_clock_output);
  endproperty
  property p_wdrv;
    !wr_n |-> !wdata_oen;
  endproperty
  property p_aleclk;
    $fell(ale) |-> $rose(system_clock_output);
  endproperty
  property p_lcs;
    $fell(ale) |-> latched_chip_select == early_chip_select;
  endproperty
  property p_wgate;
    !write_gated_select_n |-> !wr_n;
  endproperty
  a_taken: assert property (p_taken) else $error("cycle not started");
  a_start: assert property (p_start) else $error("address phase wrong");
  a_idle: assert property (p_idle) else $error("idle outputs wrong");
  a_excl: assert property (p_excl) else $error("both commands low");
  a_gate: assert property (p_gate) else $error("gated select without read");
  a_done: assert property (p_done) else $error("done too long");
  a_clk: assert property (p_clk) else $error("clock output too fast");
  a_wdrv: assert property (p_wdrv) else $error("write data not driven");
  a_aleclk: assert property (p_aleclk) else $error("strobe fall not at clock rise");
  a_lcs: assert property (p_lcs) else $error("latched select differs");
  a_wgate: assert property (p_wgate) else $error("gated select without write");
endmodule

bind ebc_bus_ctrl ebc_checker #(.AW(AW), .CSN(CSN)) u_chk (.clk, .rstn, .req_ack, .req_addr, .req_cs, .busy,
  .done, .rd_n, .wr_n, .read_gated_select_n, .wdata_oen, .ale, .addr, .early_chip_select, .system_clock_output,
  .latched_chip_select, .write_gated_select_n);

// file: ebc_defs.vh
`ifndef EBC_DEFS_VH
`define EBC_DEFS_VH
// Phase timing, in half-clock units, then waitstate field and sync widths
`define EBC_BASE_HALF 5'h04
`define EBC_MCW_W 4
`define EBC_READY_SYNC_W 2
// Command low time without read/write delay, minus the closing unit
`define EBC_CMD_HALF 5'h02
// Bus states
`define EBC_ST_IDLE 3'h0
`define EBC_ST_ADDR 3'h1
`define EBC_ST_SETUP 3'h2
`define EBC_ST_CMD 3'h3
`define EBC_ST_WAIT 3'h4
`define EBC_ST_RECOV 3'h5
`endif

// file: ebc_mem.sv
`timescale 1ns/1ns
module ebc_mem (
  input wire clk,
  input wire rd_n,
  input wire wr_n,
  input wire [23:0] addr,
  input wire [7:0] hold,
  output reg ready_n,
  output reg [15:0] data_in
);
  reg [7:0] cnt;
  initial begin
    ready_n = 1'b1;
    data_in = 16'h0000;
    cnt = 8'h00;
  end
  always @(posedge clk) begin
    if (rd_n && wr_n) begin
      cnt <= 8'h00;
      ready_n <= 1'b1;
      // Released bus keeps changing so stale data cannot pass
      data_in <= ~data_in;
    end else begin
      cnt <= cnt + 8'h01;
      ready_n <= (cnt < hold);
      if (!rd_n) data_in <= ~addr[15:0];
    end
  end
endmodule

// file: ebc_sync.v
`timescale 1ns/1ns
module ebc_sync #(
  parameter W = 1
) (
  clk,
  rstn,
  d,
  q
);
  input wire clk;
  input wire rstn;
  input wire [W-1:0] d;
  output reg [W-1:0] q;
  reg [W-1:0] s1_r;
  always @(posedge clk) begin
    if (!rstn) begin
      s1_r <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      s1_r <= d;
      q <= s1_r;
    end
  end
endmodule

// file: tb.sv
`timescale 1ns/1ns
module tb;
  reg clk = 0, rstn = 0, cpu_clk = 0, req = 0, req_write = 0, req_byte_high = 0, req_mux = 0;
  reg req_setup_delay = 0, req_rw_delay = 0, req_ready_en = 1, tristate_waitstate = 0;
  reg [23:0] req_addr = 24'h000000;
  reg [15:0] req_wdata = 16'h0000;
  reg [3:0] req_cs = 4'h1, memory_cycle_waitstates = 4'h0;
  reg [7:0] hold = 8'h00;
  wire req_ack, done, busy, rd_n, wr_n, ale, wdata_oen, byte_high_enable, ready_n, system_clock_output;
  wire read_gated_select_n, write_gated_select_n;
  wire [23:0] addr;
  wire [15:0] wdata, rdata, data_in;
  wire [3:0] latched_chip_select, early_chip_select;
  integer n_mismatch = 0, num_checks = 0, cyc = 0, lowc = 0;
  ebc_bus_ctrl uut (.clk, .rstn, .cpu_clk, .ready_n, .req, .req_write, .req_addr, .req_wdata, .req_byte_high,
    .req_cs, .req_mux, .req_setup_delay, .req_rw_delay, .req_ready_en, .memory_cycle_waitstates,
    .tristate_waitstate, .req_ack, .done, .rdata, .addr, .wdata, .wdata_oen, .byte_high_enable, .ale, .rd_n,
    .wr_n, .read_gated_select_n, .write_gated_select_n, .latched_chip_select, .early_chip_select,
    .system_clock_output, .busy, .data_in);
  ebc_mem mem (.clk(clk), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .hold(hold), .ready_n(ready_n),
    .data_in(data_in));
  always #10 clk = ~clk;
  always #80 cpu_clk = ~cpu_clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!(rd_n && wr_n)) lowc <= lowc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      end_sim;
    end
  end
  task end_sim;
    begin
      if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0s expected %0h seen %0h", nm, e, g);
      end
    end
  endtask
  // Count of clk edges from the taking edge through the one where busy drops
  task run(input w, input s, input r, input x, input t, input [3:0] m, output integer len);
    begin
      @(posedge clk);
      #2;
      req_write = w;
      req_setup_delay = s;
      req_rw_delay = r;
      req_mux = x;
      tristate_waitstate = t;
      memory_cycle_waitstates = m;
      req_addr = req_addr + 24'h010203;
      req_wdata = ~req_wdata;
      req_cs = {req_cs[2:0], req_cs[3]};
      req_byte_high = ~req_byte_high;
      req = 1'b1;
      while (req_ack !== 1'b1) begin
        @(posedge clk);
        #2;
      end
      @(posedge clk);
      #2;
      req = 1'b0;
      lowc = 0;
      len = 1;
      while (busy === 1'b1) begin
        @(posedge clk);
        #2;
        len = len + 1;
      end
      if (!w) chk("rdata", {16'h0000, ~req_addr[15:0]}, rdata);
      if (w) chk("wdata", req_wdata, wdata);
      chk("bhe", req_byte_high, byte_high_enable);
    end
  endtask
  task t_timing;
    integer a0, a1, a2;
    begin
      run(0, 0, 0, 0, 0, 4'h0, a0);
      chk("base", 17, a0);
      chk("low", 12, lowc);
      run(0, 0, 0, 0, 0, 4'h1, a1);
      chk("mcw", 12, a1 - a0);
      run(0, 1, 0, 0, 0, 4'h0, a2);
      chk("setup", 8, a2 - a0);
      run(1, 0, 1, 0, 0, 4'h0, a2);
      chk("rwlow", 8, lowc);
    end
  endtask
  task t_ready;
    integer a0, a1, a2;
    begin
      run(0, 0, 0, 0, 0, 4'h0, a0);
      hold = 8'h28;
      run(0, 0, 0, 0, 0, 4'h0, a1);
      req_ready_en = 1'b0;
      run(0, 0, 0, 0, 0, 4'h0, a2);
      req_ready_en = 1'b1;
      hold = 8'h00;
      chk("ready", 32, a1 - a0);
      chk("noready", 17, a2);
    end
  endtask
  task t_mux;
    integer a0, a1, a2;
    begin
      run(1, 0, 0, 0, 0, 4'h0, a0);
      run(1, 0, 0, 1, 0, 4'h0, a1);
      chk("mux", 8, a1 - a0);
      run(0, 0, 0, 1, 1, 4'h0, a2);
      chk("gap", 16, a2 - a0);
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #2;
    rstn = 1'b1;
    t_timing;
    t_ready;
    t_mux;
    end_sim;
  end
endmodule
